// >>> rtl/awu_map.svh
// Constants of the address watchpoint unit: sizes, selects, bit positions
`ifndef AWU_MAP_SVH
`define AWU_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define AWU_NUM_IW 6
`define AWU_NUM_IR 3
`define AWU_NUM_DW 2
`define AWU_ADDR_W 32
`define AWU_CNT_W 16
`define AWU_SEL_W 5
`define AWU_STAT_W 12

// ----------------------------------------------------------------------
// Register selects on the register port
// ----------------------------------------------------------------------
`define AWU_SEL_IADDR0 5'h00
`define AWU_SEL_ICNT0 5'h06
`define AWU_SEL_ICTL 5'h0C
`define AWU_SEL_DADDR0 5'h0D
`define AWU_SEL_DCNT0 5'h0F
`define AWU_SEL_DCTL 5'h11
`define AWU_SEL_STATUS 5'h12

// ----------------------------------------------------------------------
// Instruction watch control bit positions
// ----------------------------------------------------------------------
`define AWU_IC_POWER 0
`define AWU_IC_AND 1
`define AWU_IC_EN 2
`define AWU_IC_CNTEN 8
`define AWU_IC_EMU 14
`define AWU_IC_REN 20
`define AWU_IC_RINV 23

// ----------------------------------------------------------------------
// Data watch control bit positions
// ----------------------------------------------------------------------
`define AWU_DC_REN 0
`define AWU_DC_RINV 1
`define AWU_DC_EN 2
`define AWU_DC_CNTEN 4
`define AWU_DC_DIR 6
`define AWU_DC_SRC 8

// ----------------------------------------------------------------------
// Status bit positions and reset values
// ----------------------------------------------------------------------
`define AWU_ST_IRANGE 6
`define AWU_ST_DSINGLE 9
`define AWU_ST_DRANGE 11
`define AWU_RST_WORD 32'h0000_0000
`define AWU_RST_CNT 16'h0000
`define AWU_RST_STAT 12'h000

`endif

// >>> rtl/awu_pkg.sv
// Types of the address watchpoint unit
package awu_pkg;
`include "awu_map.svh"

    // State of the top-level unit
    typedef struct packed {
        logic [`AWU_NUM_IW-1:0][`AWU_ADDR_W-1:0] ia;
        logic [`AWU_NUM_DW-1:0][`AWU_ADDR_W-1:0] da;
        logic [31:0] ictl;
        logic [31:0] dctl;
        logic [`AWU_STAT_W-1:0] status;
        logic emu;
        logic exc;
        logic [31:0] rdata;
    } awu_state_t;

    // State of one match counter
    typedef struct packed {
        logic [`AWU_CNT_W-1:0] count;
    } awu_cnt_state_t;
endpackage

// >>> rtl/awu_match_counter.sv
// One 16-bit match counter with software load
module awu_match_counter import awu_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [`AWU_CNT_W-1:0] load_value,
    input wire logic count_enable,
    input wire logic hit,
    output logic fire,
    output logic [`AWU_CNT_W-1:0] count
);
    awu_cnt_state_t st;
    awu_cnt_state_t next_st;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Load beats a match; a spent counter rests at zero until reloaded
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = load_value;
        end else if (hit && count_enable && st.count != `AWU_RST_CNT) begin
            next_st.count = st.count - 16'h0001;
        end
    end

    // Fires at once without counting, else only from zero
    assign fire = hit && (!count_enable || st.count == `AWU_RST_CNT);
    assign count = st.count;

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '{count: `AWU_RST_CNT};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_CNT_DECREMENT: assert property (@(posedge clk) disable iff (reset)
        hit && count_enable && !load && count != 16'h0000
        |=> count == $past(count) - 16'h0001)
        else $error("match counter did not decrement by one");
    AST_CNT_HOLD_ZERO: assert property (@(posedge clk) disable iff (reset)
        count == 16'h0000 && !load |=> count == 16'h0000)
        else $error("spent counter reloaded itself");
endmodule // awu_match_counter

// >>> rtl/awu_top.sv
// Address watchpoint unit: comparators, ranges, counters, status, events
module awu_top import awu_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic core_privileged,
    input wire logic reg_write,
    input wire logic [`AWU_SEL_W-1:0] reg_select,
    input wire logic [31:0] reg_wdata,
    input wire logic instr_fetch_valid,
    input wire logic [`AWU_ADDR_W-1:0] instr_fetch_addr,
    input wire logic [1:0] data_bus_valid,
    input wire logic [1:0] data_bus_write,
    input wire logic [`AWU_ADDR_W-1:0] data_bus_addr0,
    input wire logic [`AWU_ADDR_W-1:0] data_bus_addr1,
    output logic [31:0] reg_read_data,
    output logic [`AWU_STAT_W-1:0] watch_status,
    output logic emulation_event,
    output logic exception_event
);
    awu_state_t st;
    awu_state_t next_st;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Privileged write strobe shared by every register select
    logic wen;
    assign wen = reg_write && core_privileged;

    // Write to one select; strobe and select are arguments so that a
    // port connection using this re-evaluates when they move
    function automatic logic wr_to(
        input logic en,
        input logic [`AWU_SEL_W-1:0] s,
        input logic [`AWU_SEL_W-1:0] k
    );
        wr_to = en && s == k;
    endfunction

    // Range test; invert picks the outside of the range
    function automatic logic in_range(
        input logic [`AWU_ADDR_W-1:0] a,
        input logic [`AWU_ADDR_W-1:0] lo,
        input logic [`AWU_ADDR_W-1:0] hi,
        input logic inv
    );
        in_range = ((a >= lo) && (a <= hi)) ^ inv;
    endfunction

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    logic power;
    logic and_mode;
    logic [`AWU_NUM_IW-1:0] i_en;
    logic [`AWU_NUM_IW-1:0] i_cnt_en;
    logic [`AWU_NUM_IW-1:0] i_emu;
    logic [`AWU_NUM_IR-1:0] i_ren;
    logic [`AWU_NUM_IR-1:0] i_rinv;
    logic d_ren;
    logic d_rinv;
    logic [`AWU_NUM_DW-1:0] d_en;
    logic [`AWU_NUM_DW-1:0] d_cnt_en;
    logic [`AWU_NUM_DW-1:0] d_dir;
    logic [`AWU_NUM_DW-1:0] d_src;

    // Field slices of the two control words
    assign power = st.ictl[`AWU_IC_POWER];
    assign and_mode = st.ictl[`AWU_IC_AND];
    assign i_en = st.ictl[`AWU_IC_EN +: `AWU_NUM_IW];
    assign i_cnt_en = st.ictl[`AWU_IC_CNTEN +: `AWU_NUM_IW];
    assign i_emu = st.ictl[`AWU_IC_EMU +: `AWU_NUM_IW];
    assign i_ren = st.ictl[`AWU_IC_REN +: `AWU_NUM_IR];
    assign i_rinv = st.ictl[`AWU_IC_RINV +: `AWU_NUM_IR];
    assign d_ren = st.dctl[`AWU_DC_REN];
    assign d_rinv = st.dctl[`AWU_DC_RINV];
    assign d_en = st.dctl[`AWU_DC_EN +: `AWU_NUM_DW];
    assign d_cnt_en = st.dctl[`AWU_DC_CNTEN +: `AWU_NUM_DW];
    assign d_dir = st.dctl[`AWU_DC_DIR +: `AWU_NUM_DW];
    assign d_src = st.dctl[`AWU_DC_SRC +: `AWU_NUM_DW];

    // ------------------------------------------------------------------
    // Instruction comparators and ranges
    // ------------------------------------------------------------------
    logic [`AWU_NUM_IW-1:0] i_hit;
    logic [`AWU_NUM_IW-1:0] i_fire;
    logic [`AWU_CNT_W-1:0] i_count [`AWU_NUM_IW];
    logic [`AWU_NUM_IR-1:0] i_rng_fire;
    logic [`AWU_NUM_IW-1:0] i_single_fire;

    // Pair p uses comparator 2p as lower bound and 2p+1 as upper
    generate
        for (genvar p = 0; p < `AWU_NUM_IR; p++) begin : g_ipair
            logic eq_lo;
            logic eq_hi;
            logic rng;
            assign eq_lo = instr_fetch_addr == st.ia[2*p];
            assign eq_hi = instr_fetch_addr == st.ia[2*p+1];
            // Bounds assumed ordered by software
            assign rng = in_range(instr_fetch_addr, st.ia[2*p],
                st.ia[2*p+1], i_rinv[p]);
            // A range borrows the lower comparator's enable and counter
            assign i_hit[2*p] = power && instr_fetch_valid && i_en[2*p]
                && (i_ren[p] ? rng : eq_lo);
            assign i_hit[2*p+1] = power && instr_fetch_valid && !i_ren[p]
                && i_en[2*p+1] && eq_hi;
            assign i_rng_fire[p] = i_ren[p] && i_fire[2*p];
            assign i_single_fire[2*p] = !i_ren[p] && i_fire[2*p];
            assign i_single_fire[2*p+1] = i_fire[2*p+1];
        end
        for (genvar i = 0; i < `AWU_NUM_IW; i++) begin : g_icnt
            awu_match_counter u_cnt (
                .clk(clk),
                .reset(reset),
                .load(wr_to(wen, reg_select,
                    5'(`AWU_SEL_ICNT0 + i))),
                .load_value(reg_wdata[`AWU_CNT_W-1:0]),
                .count_enable(i_cnt_en[i]),
                .hit(i_hit[i]),
                .fire(i_fire[i]),
                .count(i_count[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Data comparators and range
    // ------------------------------------------------------------------
    logic [`AWU_NUM_DW-1:0] d_hit;
    logic [`AWU_NUM_DW-1:0] d_fire;
    logic [`AWU_CNT_W-1:0] d_count [`AWU_NUM_DW];
    logic [`AWU_ADDR_W-1:0] d_addr [`AWU_NUM_DW];
    logic [`AWU_NUM_DW-1:0] d_access;
    logic d_rng;

    // Each watchpoint picks its generator and access direction
    generate
        for (genvar n = 0; n < `AWU_NUM_DW; n++) begin : g_data
            assign d_addr[n] = d_src[n] ? data_bus_addr1 : data_bus_addr0;
            assign d_access[n] = d_src[n]
                ? (data_bus_valid[1] && data_bus_write[1] == d_dir[n])
                : (data_bus_valid[0] && data_bus_write[0] == d_dir[n]);
            awu_match_counter u_cnt (
                .clk(clk),
                .reset(reset),
                .load(wr_to(wen, reg_select,
                    5'(`AWU_SEL_DCNT0 + n))),
                .load_value(reg_wdata[`AWU_CNT_W-1:0]),
                .count_enable(d_cnt_en[n]),
                .hit(d_hit[n]),
                .fire(d_fire[n]),
                .count(d_count[n])
            );
        end
    endgenerate

    // The range follows watchpoint 0's source and direction
    assign d_rng = in_range(d_addr[0], st.da[0], st.da[1], d_rinv);
    assign d_hit[0] = power && d_access[0] && d_en[0]
        && (d_ren ? d_rng : d_addr[0] == st.da[0]);
    assign d_hit[1] = power && d_access[1] && d_en[1] && !d_ren
        && d_addr[1] == st.da[1];

    // ------------------------------------------------------------------
    // Event combining
    // ------------------------------------------------------------------
    logic [`AWU_STAT_W-1:0] fired;
    logic i_any;
    logic d_any;
    logic i_emu_fire;
    logic i_exc_fire;
    logic [`AWU_NUM_IR-1:0] rng_emu;
    logic both;

    // Sources in status order
    assign fired = {d_ren & d_fire[0], d_fire & {~d_ren, ~d_ren},
        i_rng_fire, i_single_fire};
    assign i_any = |fired[`AWU_ST_DSINGLE-1:0];
    assign d_any = |fired[`AWU_STAT_W-1:`AWU_ST_DSINGLE];
    generate
        for (genvar p = 0; p < `AWU_NUM_IR; p++) begin : g_remu
            assign rng_emu[p] = i_emu[2*p];
        end
    endgenerate
    // A range takes its event type from its lower comparator
    assign i_emu_fire = |(i_single_fire & i_emu)
        || |(i_rng_fire & rng_emu);
    assign i_exc_fire = |(i_single_fire & ~i_emu)
        || |(i_rng_fire & ~rng_emu);
    assign both = i_any && d_any;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Reads return the old value; unprivileged reads see zero
    always_comb begin
        next_st = st;
        next_st.rdata = `AWU_RST_WORD;
        if (core_privileged) begin
            for (int i = 0; i < `AWU_NUM_IW; i++) begin
                if (reg_select == 5'(`AWU_SEL_IADDR0 + i)) begin
                    next_st.rdata = st.ia[i];
                end
                if (reg_select == 5'(`AWU_SEL_ICNT0 + i)) begin
                    next_st.rdata = {16'h0000, i_count[i]};
                end
            end
            for (int n = 0; n < `AWU_NUM_DW; n++) begin
                if (reg_select == 5'(`AWU_SEL_DADDR0 + n)) begin
                    next_st.rdata = st.da[n];
                end
                if (reg_select == 5'(`AWU_SEL_DCNT0 + n)) begin
                    next_st.rdata = {16'h0000, d_count[n]};
                end
            end
            if (reg_select == `AWU_SEL_ICTL) begin
                next_st.rdata = st.ictl;
            end
            if (reg_select == `AWU_SEL_DCTL) begin
                next_st.rdata = st.dctl;
            end
            if (reg_select == `AWU_SEL_STATUS) begin
                next_st.rdata = {20'h0_0000, st.status};
            end
        end
        // Register writes
        for (int i = 0; i < `AWU_NUM_IW; i++) begin
            if (wr_to(wen, reg_select, 5'(`AWU_SEL_IADDR0 + i))) begin
                next_st.ia[i] = reg_wdata;
            end
        end
        for (int n = 0; n < `AWU_NUM_DW; n++) begin
            if (wr_to(wen, reg_select, 5'(`AWU_SEL_DADDR0 + n))) begin
                next_st.da[n] = reg_wdata;
            end
        end
        if (wr_to(wen, reg_select, `AWU_SEL_ICTL)) begin
            next_st.ictl = reg_wdata;
        end
        if (wr_to(wen, reg_select, `AWU_SEL_DCTL)) begin
            next_st.dctl = reg_wdata;
        end
        // Events: AND mode needs both sides, reported as emulation
        if (and_mode) begin
            next_st.emu = both;
            next_st.exc = 1'b0;
        end else begin
            next_st.emu = i_emu_fire || d_any;
            next_st.exc = i_exc_fire;
        end
        // Any write clears; a same-cycle source still lands
        if (wr_to(wen, reg_select, `AWU_SEL_STATUS)) begin
            next_st.status = `AWU_RST_STAT;
        end
        if (!and_mode || both) begin
            next_st.status = next_st.status | fired;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign reg_read_data = st.rdata;
    assign watch_status = st.status;
    assign emulation_event = st.emu;
    assign exception_event = st.exc;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_POWER_OFF_QUIET: assert property (
        !power |=> !emulation_event && !exception_event)
        else $error("event raised while unit powered down");
    AST_AND_NEEDS_BOTH: assert property (
        and_mode && !both |=> !emulation_event && !exception_event)
        else $error("combined mode fired without both sides");
    AST_AND_FIRES: assert property (
        and_mode && both |=> emulation_event ##0 !exception_event)
        else $error("combined mode missed a joint match");
    AST_DATA_EMULATION: assert property (
        !and_mode && d_any && !i_exc_fire
        |=> emulation_event && !exception_event)
        else $error("data match did not give emulation event only");
    AST_EXC_NEXT_CYCLE: assert property (
        !and_mode && i_exc_fire |=> exception_event)
        else $error("exception event not on following cycle");
    AST_NO_COUNT_IMMEDIATE: assert property (
        power && instr_fetch_valid && i_en[1] && !i_cnt_en[1]
        && !i_ren[0] && instr_fetch_addr == st.ia[1] && !and_mode
        |=> watch_status[1] && (emulation_event || exception_event))
        else $error("uncounted match did not fire at once");
    AST_DISABLED_SILENT: assert property (
        !i_en[3] |-> !i_hit[3])
        else $error("disabled comparator produced a hit");
    AST_STATUS_STICKY: assert property (
        !(reg_write && core_privileged && reg_select == `AWU_SEL_STATUS)
        |=> (watch_status & $past(watch_status)) == $past(watch_status))
        else $error("status bit dropped without a clear");
    AST_STATUS_CLEAR: assert property (
        reg_write && core_privileged && reg_select == `AWU_SEL_STATUS
        && fired == 12'h000 |=> watch_status == 12'h000)
        else $error("status write did not clear all bits");
    AST_UNPRIV_READ_ZERO: assert property (
        !core_privileged |=> reg_read_data == 32'h0000_0000)
        else $error("unprivileged read returned data");
    AST_UNPRIV_WRITE_IGNORED: assert property (
        reg_write && !core_privileged |=> $stable(st.ictl)
        && $stable(st.dctl) && $stable(st.ia))
        else $error("unprivileged write changed a register");

    COV_OR_EXCEPTION: cover property (!and_mode && i_exc_fire ##1 exception_event);
    COV_AND_EVENT: cover property (and_mode && both ##1 emulation_event);
    COV_IRANGE_FIRE: cover property (|i_rng_fire ##1 |watch_status[8:6]);
    COV_STATUS_CLEAR: cover property (
        watch_status != 12'h000 ##1 watch_status == 12'h000);
endmodule // awu_top

// >>> testbench/awu_core_bus.sv
// Behavioural model of the core fetch and data address buses
module awu_core_bus (
    input wire logic clk,
    output logic instr_fetch_valid,
    output logic [31:0] instr_fetch_addr,
    output logic [1:0] data_bus_valid,
    output logic [1:0] data_bus_write,
    output logic [31:0] data_bus_addr0,
    output logic [31:0] data_bus_addr1
);
    timeunit 1ns;
    timeprecision 1ps;

    // Buses idle at time zero
    initial begin
        instr_fetch_valid = 1'b0;
        instr_fetch_addr = 32'h0000_0000;
        data_bus_valid = 2'b00;
        data_bus_write = 2'b00;
        data_bus_addr0 = 32'h0000_0000;
        data_bus_addr1 = 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // One bus cycle
    // ------------------------------------------------------------------
    // Released lines show inverted values, so a stale match cannot pass
    task automatic bus(input logic iv, input logic [31:0] ia,
        input logic [1:0] dv, input logic [1:0] dw, input logic [31:0] da);
        @(posedge clk);
        #1;
        instr_fetch_valid = iv;
        instr_fetch_addr = ia;
        data_bus_valid = dv;
        data_bus_write = dw;
        data_bus_addr0 = dv[0] ? da : ~da;
        data_bus_addr1 = dv[1] ? da : ~da;
        @(posedge clk);
        #1;
        instr_fetch_valid = 1'b0;
        instr_fetch_addr = ~ia;
        data_bus_valid = 2'b00;
        data_bus_write = ~dw;
        data_bus_addr0 = ~data_bus_addr0;
        data_bus_addr1 = ~data_bus_addr1;
    endtask
endmodule // awu_core_bus

// >>> testbench/awu_top_test.sv
// Self-checking testbench of the address watchpoint unit
`include "awu_map.svh"
module awu_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import awu_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic core_privileged = 1'b1;
    logic reg_write = 1'b0;
    logic [4:0] reg_select = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_read_data, instr_fetch_addr;
    logic [31:0] data_bus_addr0, data_bus_addr1;
    logic instr_fetch_valid, emulation_event, exception_event;
    logic [1:0] data_bus_valid, data_bus_write;
    logic [11:0] watch_status;
    logic [31:0] adr [4] = '{32'h0000_00FF, 32'h0000_0100,
        32'h0000_01FF, 32'h0000_0200};
    logic ok;
    int err_total = 0;
    int num_checks = 0;

    awu_top u_dut (.clk, .reset, .core_privileged, .reg_write, .reg_select,
        .reg_wdata, .instr_fetch_valid, .instr_fetch_addr, .data_bus_valid,
        .data_bus_write, .data_bus_addr0, .data_bus_addr1, .reg_read_data,
        .watch_status, .emulation_event, .exception_event);
    awu_core_bus u_core (.clk, .instr_fetch_valid, .instr_fetch_addr,
        .data_bus_valid, .data_bus_write, .data_bus_addr0, .data_bus_addr1);

    // 25 MHz core clock
    initial begin
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Events and status seen together as one word
    task automatic chk_ev(input logic [1:0] e, input logic [11:0] st);
        chk({18'h0, emulation_event, exception_event, watch_status},
            {18'h0, e, st});
    endtask
    task automatic wr(input logic [4:0] s, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_write = 1'b1;
        reg_select = s;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] s, input logic [31:0] e);
        @(posedge clk);
        #1;
        reg_select = s;
        @(posedge clk);
        #1;
        chk(reg_read_data, e);
    endtask
    // One bus cycle, then pulse length, stickiness and clear
    task automatic probe(input logic iv, input logic [31:0] ia,
        input logic [1:0] dv, input logic [1:0] dw, input logic [31:0] da,
        input logic [1:0] e, input logic [11:0] st);
        u_core.bus(iv, ia, dv, dw, da);
        chk_ev(e, st);
        @(posedge clk);
        #1;
        chk_ev(2'b00, st);
        wr(`AWU_SEL_STATUS, 32'h0000_0000);
        chk_ev(2'b00, 12'h000);
    endtask
    task automatic fi(input logic [31:0] a, input logic [1:0] e,
        input logic [11:0] st);
        probe(1'b1, a, 2'b00, 2'b00, 32'h0000_0000, e, st);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 320 cycles, allow about sixty times that
    initial begin
        #800us;
        err_total++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        chk_ev(2'b00, 12'h000);
        rd(`AWU_SEL_ICTL, 32'h0000_0000);
        wr(`AWU_SEL_IADDR0, 32'h0000_1000);
        wr(`AWU_SEL_ICTL, 32'h0000_0004);
        fi(32'h0000_1000, 2'b00, 12'h000);
        wr(`AWU_SEL_ICTL, 32'h0000_0005);
        fi(32'h0000_1000, 2'b01, 12'h001);
        fi(32'h0000_1004, 2'b00, 12'h000);
        wr(`AWU_SEL_IADDR0 + 5'h01, 32'h0000_1100);
        fi(32'h0000_1100, 2'b00, 12'h000);
        // Comparator 1 enabled without its counter fires at once
        wr(`AWU_SEL_ICTL, 32'h0000_000D);
        fi(32'h0000_1100, 2'b01, 12'h002);
        // Unprivileged access reads zero and cannot write
        core_privileged = 1'b0;
        rd(`AWU_SEL_ICTL, 32'h0000_0000);
        wr(`AWU_SEL_ICTL, 32'h0000_0000);
        core_privileged = 1'b1;
        rd(`AWU_SEL_ICTL, 32'h0000_000D);
        wr(`AWU_SEL_ICTL, 32'h0000_4005);
        fi(32'h0000_1000, 2'b10, 12'h001);
        // Count of one: first match counts down, later ones all fire
        wr(`AWU_SEL_ICNT0, 32'h0000_0001);
        wr(`AWU_SEL_ICTL, 32'h0000_4105);
        fi(32'h0000_1000, 2'b00, 12'h000);
        rd(`AWU_SEL_ICNT0, 32'h0000_0000);
        fi(32'h0000_1000, 2'b10, 12'h001);
        fi(32'h0000_1000, 2'b10, 12'h001);
        rd(`AWU_SEL_ICNT0, 32'h0000_0000);
        // Every pair as range, inside then outside
        for (int p = 0; p < 3; p++) begin
            wr(`AWU_SEL_IADDR0 + 5'(2 * p), 32'h0000_0100);
            wr(`AWU_SEL_IADDR0 + 5'(2 * p + 1), 32'h0000_01FF);
            for (int v = 0; v < 2; v++) begin
                wr(`AWU_SEL_ICTL, 32'h0000_0001 | (32'h0000_0004 << 2 * p)
                    | (32'h0010_0000 << p) | (32'(v) << (23 + p)));
                for (int k = 0; k < 4; k++) begin
                    ok = (k == 1 || k == 2) ^ (v == 1);
                    fi(adr[k], {1'b0, ok},
                        ok ? 12'h040 << p : 12'h000);
                end
            end
        end
        // Data watchpoint 0: write access, then direction and source
        wr(`AWU_SEL_ICTL, 32'h0000_0001);
        wr(`AWU_SEL_DADDR0, 32'h0000_2000);
        wr(`AWU_SEL_DCTL, 32'h0000_0044);
        probe(0, 0, 2'b01, 2'b01, 32'h0000_2000,
            2'b10, 12'h200);
        probe(0, 0, 2'b01, 2'b00, 32'h0000_2000, 2'b00, 12'h000);
        wr(`AWU_SEL_DCTL, 32'h0000_0144);
        probe(0, 0, 2'b01, 2'b01, 32'h0000_2000, 2'b00, 12'h000);
        probe(0, 0, 2'b10, 2'b10, 32'h0000_2000, 2'b10, 12'h200);
        wr(`AWU_SEL_DCNT0, 32'h0000_0001);
        wr(`AWU_SEL_DCTL, 32'h0000_0154);
        probe(0, 0, 2'b10, 2'b10, 32'h0000_2000, 2'b00, 12'h000);
        rd(`AWU_SEL_DCNT0, 32'h0000_0000);
        probe(0, 0, 2'b10, 2'b10, 32'h0000_2000, 2'b10, 12'h200);
        // Data range on read accesses, plain and inverted
        wr(`AWU_SEL_DADDR0, 32'h0000_3000);
        wr(`AWU_SEL_DADDR0 + 5'h01, 32'h0000_30FF);
        wr(`AWU_SEL_DCTL, 32'h0000_0005);
        probe(0, 0, 2'b01, 2'b00, 32'h0000_3080, 2'b10, 12'h800);
        wr(`AWU_SEL_DCTL, 32'h0000_0007);
        probe(0, 0, 2'b01, 2'b00, 32'h0000_3080, 2'b00, 12'h000);
        probe(0, 0, 2'b01, 2'b00, 32'h0000_4000, 2'b10, 12'h800);
        // Combine mode needs both sides in one cycle
        wr(`AWU_SEL_IADDR0, 32'h0000_1000);
        wr(`AWU_SEL_DADDR0, 32'h0000_2000);
        wr(`AWU_SEL_DCTL, 32'h0000_0044);
        wr(`AWU_SEL_ICTL, 32'h0000_0007);
        fi(32'h0000_1000, 2'b00, 12'h000);
        probe(0, 0, 2'b01, 2'b01, 32'h0000_2000, 2'b00, 12'h000);
        probe(1, 32'h0000_1000, 2'b01, 2'b01, 32'h0000_2000,
            2'b10, 12'h201);
        wr(`AWU_SEL_ICTL, 32'h0000_0005);
        probe(1, 32'h0000_1000, 2'b01, 2'b01, 32'h0000_2000,
            2'b11, 12'h201);
        conclude();
    end
endmodule // awu_top_test
